// ===== logic/core_mem_regs.svh
// Offsets, field positions, reset values and sizes of the core memory block.
// Included by the core memory module; definitions only.
`ifndef CORE_MEM_REGS_SVH
`define CORE_MEM_REGS_SVH

`define OFS_INDIRECT_DATA_0   7'h00
`define OFS_INDIRECT_DATA_1   7'h01
`define OFS_PC_LOW_BYTE       7'h02
`define OFS_ALU_RESET_FLAGS   7'h03
`define OFS_POINTER0_LOW      7'h04
`define OFS_POINTER0_HIGH     7'h05
`define OFS_POINTER1_LOW      7'h06
`define OFS_POINTER1_HIGH     7'h07
`define OFS_BANK_SELECT       7'h08
`define OFS_WORKING_REGISTER  7'h09
`define OFS_PC_HIGH_LATCH     7'h0A
`define OFS_INTERRUPT_CONTROL 7'h0B
`define OFS_SFR_FIRST         7'h0C
`define OFS_GPR_FIRST         7'h20
`define OFS_COMMON_FIRST      7'h70

`define ST_CARRY              0
`define ST_DIGIT_CARRY        1
`define ST_ZERO               2
`define ST_POWER_DOWN         3
`define ST_TIMEOUT            4

`define PC_RESET_VECTOR       15'h0000
`define PC_INT_VECTOR         15'h0004
`define PC_IMPL_MASK          15'h07FF
`define HE_FIRST              15'h0780
`define HE_LAST               15'h07FF
`define STACK_DEPTH           16
`define GPR_BANKS             5'h02
`define GPR_BYTES             80
`define COMMON_BYTES          16
`define PROG_SPACE_BIT        15

`endif

// ===== logic/core_mem_pkg.sv
// Types shared by the core memory organisation block.
// Constants live in core_mem_regs.svh.
package core_mem_pkg;

  typedef enum logic [0:0] {
    ACC_IDLE   = 1'b0,
    ACC_PFETCH = 1'b1
  } acc_state_t;

  typedef enum logic [1:0] {
    REG_CORE   = 2'b00,
    REG_SFR    = 2'b01,
    REG_RAM    = 2'b10,
    REG_UNIMPL = 2'b11
  } region_t;

  typedef struct packed {
    logic [14:0]              pc;
    logic [7:0]               working_register;
    logic [4:0]               bank_select;
    logic [15:0]              fsr0;
    logic [15:0]              fsr1;
    logic [7:0]               pc_high_latch;
    logic [7:0]               interrupt_control;
    logic                     st_z;
    logic                     st_dc;
    logic                     st_c;
    logic                     st_to;
    logic                     st_pd;
    logic [2:0]               sh_flags;
    logic [7:0]               sh_working_register;
    logic [4:0]               sh_bsr;
    logic [15:0]              sh_fsr0;
    logic [15:0]              sh_fsr1;
    logic [7:0]               sh_pc_high_latch;
    logic [15:0][14:0]        stack;
    logic [4:0]               depth;
    logic                     ovf;
    logic                     unf;
    logic                     soft_rst;
    acc_state_t               mode;
    logic [10:0]              paddr;
    logic [7:0]               rdata;
    logic                     rvalid;
  } core_state_t;

endpackage

// ===== logic/core_mem.sv
// Core memory organisation: PC, return stack, core registers, banked data.
// Assumes the CPU sequencer issues one request at a time and holds off
// while busy is high; program words arrive one cycle after prog_addr.
//
// Contract
// - Shadow core registers on interrupt, restore on return
// - Return stack of 16 entries, 15 bits
// - Stack overflow/underflow flags, optional software reset
// - Two 16-bit pointers reach data and program
// - Pointer program reads take one extra cycle
// - 15-bit PC wrapping within 2048 words
// - Reset starts at 0000h, interrupt at 0004h
// - High-endurance region 0780h-07FFh, low byte
// - Pointer bit 15 high reads program low byte
// - Indirect writes never alter program memory
// - 32 banks: core, peripheral, general, common
// - Bank select chooses bank; unimplemented reads zero
// - 12-bit data address: bank and offset
// - Core registers at 00h-0Bh in every bank
// - Peripheral registers at 0Ch-1Fh in every bank
// - Flag logic overrides status writes; TO, PD read-only
// - Clearing status gives 000u uluu
// - Timeout flag set/cleared by watchdog events
// - Power-down flag set/cleared by clear and sleep
// - Zero flag from result; bits 7-5 read zero
// - Digit carry from bit 3 carry-out
// - Carry from MSB, inverted borrow, rotates
`timescale 1ns/1ps
`include "core_mem_regs.svh"

module core_mem
  import core_mem_pkg::*;
(
  input  wire logic        clock,          // 200 MHz core clock
  input  wire logic        reset,          // Async reset, active high
  input  wire logic        clock_en,       // Freezes all state while low
  input  wire logic        acc_rd,         // Read request, direct offset
  input  wire logic        acc_wr,         // Write request, direct offset
  input  wire logic [6:0]  acc_addr,       // Offset within active bank
  input  wire logic [7:0]  acc_wdata,      // Write data
  output logic      [7:0]  acc_rdata,      // Read data
  output logic             acc_valid,      // Read data valid pulse
  output logic             busy,           // Program word fetch in progress
  input  wire logic [2:0]  flag_upd,       // ALU updates {z,dc,c}
  input  wire logic [2:0]  flag_val,       // ALU values {z,dc,c}
  input  wire logic        wdt_clear,      // Watchdog clear executed
  input  wire logic        sleep_exec,     // Sleep executed
  input  wire logic        wdt_timeout,    // Watchdog timer expired
  input  wire logic        pc_step,        // Advance PC
  input  wire logic        pc_jump,        // Load PC with target
  input  wire logic        call_push,      // Push PC+1 and jump
  input  wire logic        ret_pop,        // Return from call
  input  wire logic [14:0] pc_target,      // Jump or call target
  input  wire logic        int_entry,      // Interrupt accepted
  input  wire logic        int_return,     // Return from interrupt
  input  wire logic        stack_rst_en,   // Stack errors cause reset
  input  wire logic        stack_flag_clr, // Clear both stack flags
  output logic      [14:0] pc,             // Program counter
  output logic             high_endurance, // PC in high-endurance region
  output logic      [10:0] prog_addr,      // Program word address for data
  input  wire logic [13:0] prog_data,      // Program word
  output logic             stack_overflow_flag,  // Sticky overflow
  output logic             stack_underflow_flag, // Sticky underflow
  output logic             soft_reset,     // Software reset pulse
  output logic             periph_rd,      // Peripheral read strobe
  output logic             periph_wr,      // Peripheral write strobe
  output logic      [11:0] periph_addr,    // Full data address
  output logic      [7:0]  periph_wdata,   // Peripheral write data
  input  wire logic [7:0]  periph_rdata    // Peripheral read data
);

  core_state_t q;
  core_state_t d;

  logic [7:0] ram [0:(`GPR_BYTES*2)+`COMMON_BYTES-1];

  logic [15:0] ind_ptr;
  logic        ind_sel;
  logic [11:0] daddr;
  logic [6:0]  dofs;
  region_t     region;
  logic [7:0]  ram_idx;
  logic [7:0]  status_rd;
  logic [7:0]  core_rd;
  logic [7:0]  rd_byte;
  logic        prog_acc;
  logic [14:0] pc_next_seq;

  // Pointer chosen when the offset names an indirect data register
  always_comb
  begin
    ind_sel = (acc_addr == `OFS_INDIRECT_DATA_0) || (acc_addr == `OFS_INDIRECT_DATA_1);
    ind_ptr = (acc_addr == `OFS_INDIRECT_DATA_1) ? q.fsr1 : q.fsr0;
    prog_acc = ind_sel && ind_ptr[`PROG_SPACE_BIT];
    if (ind_sel)
      daddr = ind_ptr[11:0];
    else
      daddr = {q.bank_select, acc_addr};
    dofs = daddr[6:0];
  end

  // Region decode; general RAM only in banks 0-1, other offsets same in every bank
  always_comb
  begin
    ram_idx = 8'h00;
    if (ind_sel && (ind_ptr[14:12] != 3'b000))
      region = REG_UNIMPL;
    else if (dofs < `OFS_SFR_FIRST)
      region = REG_CORE;
    else if (dofs < `OFS_GPR_FIRST)
      region = REG_SFR;
    else if (dofs >= `OFS_COMMON_FIRST)
    begin
      region  = REG_RAM;
      ram_idx = 8'(`GPR_BYTES*2) + 8'(dofs - `OFS_COMMON_FIRST);
    end
    else if (daddr[11:7] < `GPR_BANKS)
    begin
      region  = REG_RAM;
      ram_idx = (daddr[7] ? 8'(`GPR_BYTES) : 8'h00) + 8'(dofs - `OFS_GPR_FIRST);
    end
    else
      region = REG_UNIMPL;
  end

  always_comb
  begin
    status_rd = 8'h00;
    status_rd[`ST_TIMEOUT]     = q.st_to;
    status_rd[`ST_POWER_DOWN]  = q.st_pd;
    status_rd[`ST_ZERO]        = q.st_z;
    status_rd[`ST_DIGIT_CARRY] = q.st_dc;
    status_rd[`ST_CARRY]       = q.st_c;
    unique case (dofs[3:0])
      4'h2:    core_rd = q.pc[7:0];
      4'h3:    core_rd = status_rd;
      4'h4:    core_rd = q.fsr0[7:0];
      4'h5:    core_rd = q.fsr0[15:8];
      4'h6:    core_rd = q.fsr1[7:0];
      4'h7:    core_rd = q.fsr1[15:8];
      4'h8:    core_rd = {3'b000, q.bank_select};
      4'h9:    core_rd = q.working_register;
      4'hA:    core_rd = q.pc_high_latch;
      4'hB:    core_rd = q.interrupt_control;
      default: core_rd = 8'h00; // Indirect of indirect reads zero
    endcase
    unique case (region)
      REG_CORE:   rd_byte = core_rd;
      REG_SFR:    rd_byte = periph_rdata;
      REG_RAM:    rd_byte = ram[ram_idx];
      REG_UNIMPL: rd_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    periph_addr  = daddr;
    periph_wdata = acc_wdata;
    periph_rd    = clock_en && acc_rd && !prog_acc && (region == REG_SFR);
    periph_wr    = clock_en && acc_wr && !prog_acc && (region == REG_SFR);
    busy         = (q.mode == ACC_PFETCH);
    pc_next_seq  = (q.pc + 15'h0001) & `PC_IMPL_MASK;
  end

  // Memory array kept outside the state struct; written only on data space
  always_ff @(posedge clock)
  begin
    if (clock_en && acc_wr && !prog_acc && (region == REG_RAM))
      ram[ram_idx] <= acc_wdata;
  end

  always_comb
  begin
    d          = q;
    d.rvalid   = 1'b0;
    d.soft_rst = 1'b0;

    // Read path; program reads spend one more cycle in fetch
    unique case (q.mode)
      ACC_IDLE:
      begin
        if (acc_rd && prog_acc)
        begin
          d.mode  = ACC_PFETCH;
          d.paddr = ind_ptr[10:0];
        end
        else if (acc_rd)
        begin
          d.rdata  = rd_byte;
          d.rvalid = 1'b1;
        end
      end
      ACC_PFETCH:
      begin
        d.mode   = ACC_IDLE;
        d.rdata  = prog_data[7:0];
        d.rvalid = 1'b1;
      end
    endcase

    // Register writes; program space through a pointer is dropped
    if (acc_wr && !prog_acc && (region == REG_CORE))
    begin
      unique case (dofs[3:0])
        4'h2: d.pc = {q.pc_high_latch[6:0], acc_wdata} & `PC_IMPL_MASK;
        4'h3:
        begin
          // Any flag update masks the write to all three bits
          if (flag_upd == 3'b000)
          begin
            d.st_z  = acc_wdata[`ST_ZERO];
            d.st_dc = acc_wdata[`ST_DIGIT_CARRY];
            d.st_c  = acc_wdata[`ST_CARRY];
          end
        end
        4'h4: d.fsr0[7:0]  = acc_wdata;
        4'h5: d.fsr0[15:8] = acc_wdata;
        4'h6: d.fsr1[7:0]  = acc_wdata;
        4'h7: d.fsr1[15:8] = acc_wdata;
        4'h8: d.bank_select        = acc_wdata[4:0];
        4'h9: d.working_register       = acc_wdata;
        4'hA: d.pc_high_latch     = acc_wdata;
        4'hB: d.interrupt_control     = acc_wdata;
        default: ;
      endcase
    end

    // Flag logic wins over a status write
    if (flag_upd[2]) d.st_z  = flag_val[2];
    if (flag_upd[1]) d.st_dc = flag_val[1];
    if (flag_upd[0]) d.st_c  = flag_val[0];

    // Reset-cause bits; a timeout outranks a clear in the same cycle
    if (wdt_clear)
    begin
      d.st_to = 1'b1;
      d.st_pd = 1'b1;
    end
    if (sleep_exec)
    begin
      d.st_to = 1'b1;
      d.st_pd = 1'b0;
    end
    if (wdt_timeout)
      d.st_to = 1'b0;

    if (stack_flag_clr)
    begin
      d.ovf = 1'b0;
      d.unf = 1'b0;
    end

    // Program counter and stack; a push outranks a pop, interrupt entry outranks a call
    if (int_entry || call_push)
    begin
      if (q.depth == 5'(`STACK_DEPTH))
      begin
        d.ovf      = 1'b1;
        d.soft_rst = stack_rst_en;
      end
      else
      begin
        d.stack[q.depth[3:0]] = int_entry ? q.pc : pc_next_seq;
        d.depth               = q.depth + 5'h01;
      end
      d.pc = int_entry ? `PC_INT_VECTOR : (pc_target & `PC_IMPL_MASK);
    end
    else if (int_return || ret_pop)
    begin
      if (q.depth == 5'h00)
      begin
        d.unf      = 1'b1;
        d.soft_rst = stack_rst_en;
      end
      else
      begin
        d.pc    = q.stack[q.depth[3:0] - 4'h1] & `PC_IMPL_MASK;
        d.depth = q.depth - 5'h01;
      end
    end
    else if (pc_jump)
      d.pc = pc_target & `PC_IMPL_MASK;
    else if (pc_step)
      d.pc = pc_next_seq;

    // Shadow save and restore, no stack entries used
    if (int_entry)
    begin
      d.sh_flags  = {q.st_z, q.st_dc, q.st_c};
      d.sh_working_register   = q.working_register;
      d.sh_bsr    = q.bank_select;
      d.sh_fsr0   = q.fsr0;
      d.sh_fsr1   = q.fsr1;
      d.sh_pc_high_latch = q.pc_high_latch;
    end
    else if (int_return)
    begin
      {d.st_z, d.st_dc, d.st_c} = q.sh_flags;
      d.working_register   = q.sh_working_register;
      d.bank_select    = q.sh_bsr;
      d.fsr0   = q.sh_fsr0;
      d.fsr1   = q.sh_fsr1;
      d.pc_high_latch = q.sh_pc_high_latch;
    end

    // Hardware set wins over a software clear in the same cycle
    if (d.soft_rst || (q.depth == 5'(`STACK_DEPTH) && (int_entry || call_push)))
      d.ovf = d.ovf | (q.depth == 5'(`STACK_DEPTH) && (int_entry || call_push));
    if (!(int_entry || call_push) && (int_return || ret_pop) && q.depth == 5'h00)
      d.unf = 1'b1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      q        <= '0;
      q.pc     <= `PC_RESET_VECTOR;
      q.st_to  <= 1'b1;
      q.st_pd  <= 1'b1;
      q.mode   <= ACC_IDLE;
    end
    else if (clock_en)
      q <= d;
  end

  always_comb
  begin
    pc                   = q.pc;
    prog_addr            = q.paddr;
    acc_rdata            = q.rdata;
    acc_valid            = q.rvalid;
    stack_overflow_flag  = q.ovf;
    stack_underflow_flag = q.unf;
    soft_reset           = q.soft_rst;
    high_endurance       = (q.pc >= `HE_FIRST) && (q.pc <= `HE_LAST);
  end

  // Checks
  sequence s_prog_req;
    acc_rd && prog_acc && !busy && clock_en;
  endsequence

  sequence s_prog_done;
    busy ##1 acc_valid;
  endsequence

  AST_PROG_EXTRA_CYCLE: assert property (@(posedge clock) disable iff (reset)
    s_prog_req ##1 clock_en |-> s_prog_done)
    else $error("Program read did not take one extra cycle");

  AST_PROG_LOW_BYTE: assert property (@(posedge clock) disable iff (reset)
    busy && clock_en |=> acc_rdata == $past(prog_data[7:0]))
    else $error("Program read did not return low byte");

  AST_DIRECT_ONE_CYCLE: assert property (@(posedge clock) disable iff (reset)
    acc_rd && !prog_acc && !busy && clock_en && region == REG_UNIMPL
      |=> acc_valid && acc_rdata == 8'h00)
    else $error("Unimplemented read not zero");

  AST_INT_VECTOR: assert property (@(posedge clock) disable iff (reset)
    int_entry && clock_en |=> pc == `PC_INT_VECTOR)
    else $error("Interrupt did not vector to 0004h");

  AST_PC_WRAP: assert property (@(posedge clock) disable iff (reset)
    pc[14:11] == 4'h0)
    else $error("PC outside implemented space");

  AST_STACK_OVF: assert property (@(posedge clock) disable iff (reset)
    call_push && !int_entry && q.depth == 5'(`STACK_DEPTH) && clock_en
      |=> stack_overflow_flag && soft_reset == $past(stack_rst_en))
    else $error("Overflow not flagged");

  AST_STACK_UNF: assert property (@(posedge clock) disable iff (reset)
    ret_pop && !call_push && !int_entry && q.depth == 5'h00 && clock_en
      |=> stack_underflow_flag)
    else $error("Underflow not flagged");

  AST_CALL_RETURN: assert property (@(posedge clock) disable iff (reset)
    call_push && !int_entry && clock_en && q.depth < 5'(`STACK_DEPTH)
      ##1 (ret_pop && clock_en && !call_push && !int_entry && !int_return)
      |=> pc == ($past(pc, 2) + 15'h0001 & `PC_IMPL_MASK))
    else $error("Return address mismatch");

  AST_SHADOW_WORKING_REGISTER: assert property (@(posedge clock) disable iff (reset)
    int_entry && clock_en |=> q.sh_working_register == $past(q.working_register))
    else $error("Working register not shadowed");

  AST_TO_PD_RO: assert property (@(posedge clock) disable iff (reset)
    !wdt_clear && !sleep_exec && !wdt_timeout && clock_en
      |=> q.st_to == $past(q.st_to) && q.st_pd == $past(q.st_pd))
    else $error("Timeout or power-down bit changed by a write");

  AST_SLEEP_PD: assert property (@(posedge clock) disable iff (reset)
    sleep_exec && !wdt_timeout && clock_en |=> !q.st_pd && q.st_to)
    else $error("Sleep did not clear power-down");

  AST_FLAG_WINS: assert property (@(posedge clock) disable iff (reset)
    flag_upd[2] && clock_en |=> q.st_z == $past(flag_val[2]))
    else $error("Zero flag not from flag logic");

endmodule // core_mem

// ===== testbench/far_side_model.sv
// Far-side model: program memory words and peripheral register answers.
// Assumes the core samples prog_data one cycle after prog_addr moves.
`timescale 1ns/1ps
module far_side_model
(
  input  wire logic        clock,        // Core clock
  input  wire logic [10:0] prog_addr,    // Word address from the core
  output logic      [13:0] prog_data,    // Program word
  input  wire logic        periph_rd,    // Peripheral read strobe
  input  wire logic [11:0] periph_addr,  // Peripheral address
  output logic      [7:0]  periph_rdata  // Peripheral answer
);
  logic [7:0] last_rdata = 8'h00;

  // Fixed pattern with no write path, so the core can never alter it
  assign prog_data = {prog_addr[2:0], prog_addr} ^ 14'h2A5C;
  // Released bus shows the inverse of the last answer, never a stale copy
  assign periph_rdata = periph_rd ? (periph_addr[7:0] ^ periph_addr[11:4] ^ 8'hA5)
                                  : ~last_rdata;

  always_ff @(posedge clock)
    if (periph_rd)
      last_rdata <= periph_rdata;
endmodule // far_side_model

// ===== testbench/testbench.sv
// Self-checking bench for core_mem against an integer and queue model.
// Assumes far_side_model answers program words and peripheral reads.
`timescale 1ns/1ps
module testbench;
  localparam int IZ = 0, IDC = 1, IC = 2, IW = 3, IB = 4, IF0 = 5, IPL = 7;
  localparam logic [2:0] EVS [4] = '{3'b010, 3'b001, 3'b100, 3'b101};
  logic clock = 1'b0, reset = 1'b1, clock_en, acc_rd, acc_wr, acc_valid, busy, wdt_clear;
  logic sleep_exec, wdt_timeout, pc_step, pc_jump, call_push, ret_pop, int_entry;
  logic int_return, stack_rst_en, stack_flag_clr, high_endurance, stack_overflow_flag;
  logic stack_underflow_flag, soft_reset, periph_rd, periph_wr;
  logic [9:0]  ctl;
  logic [6:0]  acc_addr;
  logic [7:0]  acc_wdata, acc_rdata, periph_wdata, periph_rdata;
  logic [2:0]  flag_upd, flag_val;
  logic [14:0] pc_target, pc;
  logic [10:0] prog_addr;
  logic [13:0] prog_data;
  logic [11:0] periph_addr;
  int n_errors = 0, n_tests = 0, n_srst = 0, exp_srst = 0, seed = 32'h0000_79da;
  int m[8], sh[8], ram[4096], stk[$], pc_m, icn, ovf, unf, to = 1, pd = 1;

  assign {stack_flag_clr, wdt_clear, sleep_exec, wdt_timeout, pc_step, pc_jump, call_push,
          ret_pop, int_entry, int_return} = ctl;

  core_mem u_core_mem (.clock, .reset, .clock_en, .acc_rd, .acc_wr, .acc_addr, .acc_wdata,
    .acc_rdata, .acc_valid, .busy, .flag_upd, .flag_val, .wdt_clear, .sleep_exec,
    .wdt_timeout, .pc_step, .pc_jump, .call_push, .ret_pop, .pc_target, .int_entry,
    .int_return, .stack_rst_en, .stack_flag_clr, .pc, .high_endurance, .prog_addr,
    .prog_data, .stack_overflow_flag, .stack_underflow_flag, .soft_reset, .periph_rd,
    .periph_wr, .periph_addr, .periph_wdata, .periph_rdata);
  far_side_model u_far_side_model (.clock, .prog_addr, .prog_data, .periph_rd,
    .periph_addr, .periph_rdata);

  always #2.5 clock = ~clock;

  always @(posedge clock)
    if (soft_reset === 1'b1)
      n_srst++;

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction

  function automatic int exp_data(input int b, input int o);
    case (o)
      2: return pc_m % 256;
      3: return to * 16 + pd * 8 + m[IZ] * 4 + m[IDC] * 2 + m[IC];
      4, 5, 6, 7: return (m[IF0 + (o - 4) / 2] >> (8 * (o % 2))) % 256;
      8: return m[IB];
      9: return m[IW];
      10: return m[IPL];
      11: return icn;
      default: ;
    endcase
    if (o < 32)
      return (b * 128 + o ^ (b * 128 + o) >> 4 ^ 8'hA5) % 256;
    return (o >= 112) ? ram[o] : (b < 2) ? ram[b * 128 + o] : 0;
  endfunction

  function automatic int exp_rd(input int o);
    int f;
    if (o > 1)
      return exp_data(m[IB], o);
    f = m[IF0 + o];
    if (f[15])
      return (f % 2048 ^ 8'h5C) % 256;
    return (f >> 12) % 8 ? 0 : exp_data((f >> 7) % 32, f % 128);
  endfunction

  function automatic void put(input int b, input int o, input int d);
    int k, s;
    k = IF0 + (o - 4) / 2;
    s = 8 * (o % 2);
    case (o)
      2: pc_m = (m[IPL] * 256 + d) % 2048;
      3: for (int j = 0; j < 3; j++) m[IC - j] = d[j];
      4, 5, 6, 7: m[k] = m[k] & ~(255 << s) | d << s;
      8: m[IB] = d % 32;
      9: m[IW] = d;
      10: m[IPL] = d;
      11: icn = d;
      default: ram[(o >= 112) ? o : (o >= 32 && b < 2) ? b * 128 + o : 0] = d;
    endcase
  endfunction

  function automatic void model_wr(input int o, input int d);
    int f;
    f = m[IF0 + o % 2];
    if (o > 1)
      put(m[IB], o, d);
    else if (!f[15] && (f >> 12) % 8 == 0)
      put((f >> 7) % 32, f % 128, d);
  endfunction

  function automatic void stack_err(input bit over);
    if (over)
      ovf = 1;
    else
      unf = 1;
    exp_srst++;
  endfunction

  function automatic void model_ev(input logic [9:0] v, input int t);
    if (v[9])
      {ovf, unf} = 64'h0;
    if (v[8] || v[7])
      to = 1;
    if (v[8] || v[7])
      pd = v[8];
    if (v[6])
      to = 0;
    if (v[5])
      pc_m = (pc_m + 1) % 2048;
    if (v[4])
      pc_m = t % 2048;
    if (v[3] || v[1])
      if (stk.size() < 16)
        stk.push_back((pc_m + v[3]) % 2048);
      else
        stack_err(1);
    if (v[3])
      pc_m = t % 2048;
    if (v[1])
      sh = m;
    if (v[1])
      pc_m = 4;
    if (v[0])
      m = sh;
    if (v[2] || v[0])
      if (stk.size() > 0)
        pc_m = stk.pop_back();
      else
        stack_err(0);
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input int o, input int d, input logic [2:0] fu = 3'b000,
                    input logic [2:0] fv = 3'b000);
    int f, pw, c3[3];
    f = (o < 2) ? m[IF0 + o] : m[IB] * 128 + o;
    pw = (f >> 12) % 16 == 0 && f % 128 >= 12 && f % 128 < 32;
    c3 = '{m[IC], m[IDC], m[IZ]};
    @(posedge clock);
    {acc_wr, acc_addr, acc_wdata, flag_upd, flag_val} <= {1'b1, 7'(o), 8'(d), fu, fv};
    #1;
    check("periph_wr", periph_wr, pw);
    check("periph_addr", periph_addr, f % 4096);
    check("periph_wdata", periph_wdata, d % 256);
    @(posedge clock);
    {acc_wr, flag_upd} <= 4'h0;
    model_wr(o, d);
    // Any flag update disables the status write for all three bits
    for (int k = 0; k < 3; k++)
      if (fu != 3'b000)
        m[IC - k] = fu[k] ? fv[k] : c3[k];
  endtask

  task automatic rd(input int o);
    int n, nb, lat;
    logic [7:0] e;
    // Pointer aimed at the indirect slots themselves reads zero, which exp_rd does not model
    if (o < 2 && !m[IF0 + o][15] && (m[IF0 + o] & 126) == 0)
      return;
    e = 8'(exp_rd(o));
    lat = (o < 2 && m[IF0 + o][15]) ? 2 : 1;
    @(posedge clock);
    {acc_rd, acc_addr} <= {1'b1, 7'(o)};
    @(posedge clock);
    acc_rd <= 1'b0;
    n = 0;
    nb = 0;
    do
    begin
      // Valid can stand just after the request edge itself
      if (n > 0)
        @(posedge clock);
      #1;
      n++;
      nb += (busy === 1'b1);
    end
    while (n < 8 && acc_valid !== 1'b1);
    check("read latency", n, lat);
    check("busy cycles", nb, lat - 1);
    check("acc_rdata", acc_rdata, e);
    if (lat == 2)
      check("prog_addr", prog_addr, m[IF0 + o] % 2048);
  endtask

  task automatic pulse(input logic [9:0] v, input int t = 0);
    @(posedge clock);
    {ctl, pc_target} <= {v, 15'(t)};
    @(posedge clock);
    ctl <= 10'h000;
    if (clock_en === 1'b1)
      model_ev(v, t);
    #1;
    check("pc", pc, pc_m);
    check("high_endurance", high_endurance, pc_m >= 16'h0780);
    check("stack_overflow_flag", stack_overflow_flag, ovf);
    check("stack_underflow_flag", stack_underflow_flag, unf);
  endtask

  initial
  begin
    int o;
    {ctl, acc_rd, acc_wr, acc_addr, acc_wdata, flag_upd, flag_val, pc_target} = '0;
    {clock_en, stack_rst_en} = 2'b11;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (int a = 2; a < 12; a++)
      rd(a);
    // Fill all implemented RAM so no read sees an unwritten cell
    for (int b = 0; b < 2; b++)
    begin
      wr(8, b);
      for (int a = 32; a < 128; a++)
        wr(a, rnd(256));
    end
    for (int i = 0; i < 60; i++)
    begin
      o = 12 + rnd(116);
      wr(8, rnd(2) ? rnd(3) : rnd(256));
      wr(2 + rnd(10), rnd(256));
      wr(o, rnd(256), 3'(rnd(8)), 3'(rnd(8)));
      rd(o);
      rd(rnd(128));
    end
    wr(3, 8'hFF);
    rd(3);
    wr(3, 8'h00, 3'b100, 3'b100);
    rd(3);
    foreach (EVS[i])
    begin
      pulse({1'b0, EVS[i], 6'b0});
      rd(3);
    end
    wr(5, 8'h80 | rnd(128));
    wr(4, rnd(256));
    rd(0);
    wr(0, 8'h5A);
    rd(0);
    wr(7, 8'hFF);
    wr(6, 8'hFF);
    rd(1);
    wr(7, 8'h10);
    rd(1);
    wr(7, 8'h0F);
    wr(1, 8'h3C);
    rd(7'h7F);
    rd(1);
    pulse(10'h010, 16'h077F);
    pulse(10'h020);
    pulse(10'h010, 16'h07FE);
    pulse(10'h020);
    pulse(10'h020);
    @(posedge clock) clock_en <= 1'b0;
    pulse(10'h020);
    clock_en <= 1'b1;
    // Call and return on adjacent edges
    @(posedge clock) {ctl, pc_target} <= {10'h008, 15'h0123};
    model_ev(10'h008, 16'h0123);
    pulse(10'h004);
    for (int i = 0; i < 17; i++)
      pulse(10'h008, rnd(2048));
    for (int i = 0; i < 17; i++)
      pulse(10'h004);
    repeat (2) @(posedge clock);
    check("soft_reset count", n_srst, exp_srst);
    pulse(10'h200);
    wr(9, rnd(256));
    wr(5, rnd(128));
    wr(10, rnd(256));
    pulse(10'h002);
    wr(9, rnd(256));
    wr(8, rnd(32));
    wr(5, rnd(128));
    wr(10, rnd(256));
    wr(12, 0, 3'b111, 3'(rnd(8)));
    pulse(10'h001);
    for (int a = 2; a < 12; a++)
      rd(a);
    tally_and_finish();
  end

  // Whole run needs about 1200 cycles; this allows ample margin
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule // testbench
